// ---- common/lar_consts.svh ----
`ifndef LAR_CONSTS_SVH
`define LAR_CONSTS_SVH

`define LAR_FN_RD_DEMAND    16'h0500
`define LAR_FN_RD_ORIGIN    16'h0502
`define LAR_FN_RD_LENGTH    16'h0512
`define LAR_FN_RD_FRAME     16'h0560
`define LAR_FN_RD_PARAMS    16'h0570
`define LAR_FN_RD_STATUS    16'h0576
`define LAR_FN_WR_ORIGIN    16'h050A
`define LAR_FN_WR_LENGTH    16'h051A
`define LAR_FN_WR_PARAMS    16'h0578

`define LAR_DEMAND_EMPTY    16'h00FF
`define LAR_STATUS_IN_RESET 16'h0268

`define LAR_ST_READY        0
`define LAR_ST_ERR_IRQ      2
`define LAR_ST_ONLINE       3
`define LAR_ST_IBUF_FULL    5
`define LAR_ST_OUT_LOOP_ERR 6
`define LAR_ST_IN_LOOP_ERR  9

`define LAR_PRM_RESERVED    15
`define LAR_PRM_SPARE       14
`define LAR_PRM_SECONDARY   13
`define LAR_PRM_NULL_HI     12
`define LAR_PRM_NULL_LO     8
`define LAR_PRM_EMPTY_HI    7
`define LAR_PRM_EMPTY_LO    0

`define LAR_LEN_THR_HI      15
`define LAR_LEN_THR_LO      12
`define LAR_LEN_FLD_HI      11
`define LAR_LEN_FLD_LO      4

`define LAR_WORD_RESET      16'h0000
`define LAR_PTR_RESET       12'h000

`endif

// ---- common/lar_pkg.sv ----
package lar_pkg;
  typedef logic [15:0] lar_word_t;
  typedef logic [11:0] lar_ptr_t;
  typedef logic [7:0]  lar_addr_t;
  // reply source chosen when a read function is decoded
  typedef enum logic [2:0] {
    LAR_SEL_NONE   = 3'b000,
    LAR_SEL_DEMAND = 3'b001,
    LAR_SEL_FRAME  = 3'b010,
    LAR_SEL_PARAMS = 3'b011,
    LAR_SEL_ORIGIN = 3'b100,
    LAR_SEL_LENGTH = 3'b101,
    LAR_SEL_STATUS = 3'b110
  } lar_sel_t;
endpackage

// ---- common/lar_demand_if.sv ----
`timescale 1ns/100ps
interface lar_demand_if #(parameter int W = 8);
  logic         push;
  logic [W-1:0] push_data;
  logic         pop;
  logic [W-1:0] head;
  logic         empty;
  logic         full;
  modport owner (output push, output push_data, output pop,
                 input head, input empty, input full);
  modport queue (input push, input push_data, input pop,
                 output head, output empty, output full);
endinterface

// ---- rtl/lar_demand_fifo.sv ----
`timescale 1ns/100ps
module lar_demand_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   mclk,  // 20 MHz clock
  input  wire logic   rst_b, // sync reset, active low
  lar_demand_if.queue q      // push/pop port
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          do_push;
  logic          do_pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // a push while full is dropped; full is exported so the source can hold off
  assign do_push = q.push && !q.full;
  assign do_pop  = q.pop && !q.empty;
  assign q.empty = (count_ff == '0);
  assign q.full  = (count_ff == (AW+1)'(DEPTH));
  assign q.head  = mem_ff[rd_ptr_ff];

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= q.push_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (do_pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// ---- rtl/lar_top.sv ----
`timescale 1ns/100ps
`include "lar_consts.svh"
module lar_top #(
  parameter int DEMAND_DEPTH = 16
) (
  input  wire logic        mclk,            // 20 MHz clock
  input  wire logic        rst_b,           // sync reset, active low
  input  wire logic [15:0] pio_func,        // function code
  input  wire logic        pio_rd_stb,      // read function strobe
  input  wire logic        pio_wr_stb,      // write function strobe
  input  wire logic [15:0] pio_wdata,       // write data word
  output logic      [15:0] pio_rdata,       // read data word
  output logic             pio_rvalid,      // read data valid pulse
  input  wire logic        demand_push,     // new output-data demand
  input  wire logic [7:0]  demand_addr,     // line adapter address of demand
  output logic             demand_full,     // demand queue cannot accept
  input  wire logic        cell_wr,         // one cell written into buffer
  input  wire logic        frame_end,       // that cell closes a line frame
  output logic      [11:0] buf_wr_ptr,      // buffer write displacement
  output logic      [15:0] buf_origin,      // buffer origin word
  output logic      [11:0] buf_length,      // buffer length in cells
  output logic      [3:0]  demand_thr,      // demand threshold
  output logic             secondary_line,  // loop end cell secondary flag
  output logic             spare_flag,      // loop end cell spare flag
  output logic      [4:0]  null_count,      // null cells per batch
  output logic      [7:0]  empty_count,     // empty cells per batch
  input  wire logic        reset_mode,      // adapter held in reset mode
  input  wire logic        normal_mode,     // adapter in normal mode
  input  wire logic        diag_active,     // any diagnostic mode set
  input  wire logic        loops_ready,     // static ready and loops active
  input  wire logic        ibuf_full_evt,   // batch start delayed
  input  wire logic        out_loop_err_evt,// output loop error seen
  input  wire logic        in_loop_err_evt, // input loop error seen
  output logic             ext_irq,         // normal external interrupt
  output logic             demand_irq,      // output-data demand pending
  output logic             data_avail_irq   // input data available
);
  lar_demand_if #(.W(8)) dq ();

  lar_demand_fifo #(
    .W     (8),
    .DEPTH (DEMAND_DEPTH)
  ) u_demand (
    .mclk  (mclk),
    .rst_b (rst_b),
    .q     (dq.queue)
  );

  lar_pkg::lar_word_t params_ff;
  lar_pkg::lar_word_t origin_ff;
  logic [3:0]         thr_ff;
  logic [7:0]         len_fld_ff;
  lar_pkg::lar_ptr_t  wptr_ff;
  lar_pkg::lar_ptr_t  frame_ptr_ff;
  logic               data_avail_ff;
  logic               st_ibuf_full_ff;
  logic               st_out_err_ff;
  logic               st_in_err_ff;
  lar_pkg::lar_word_t rdata_ff;
  logic               rvalid_ff;
  lar_pkg::lar_sel_t  rd_sel;
  lar_pkg::lar_word_t nxt_rdata;
  lar_pkg::lar_word_t status_word;
  lar_pkg::lar_ptr_t  len_cells;
  lar_pkg::lar_ptr_t  nxt_wptr;
  logic               rd_status;
  logic               rd_frame;
  logic               rd_demand;
  logic               any_err;

  // read decode is shared by the reply mux and the read side effects
  function automatic lar_pkg::lar_sel_t decode_rd(input logic [15:0] fn);
    unique case (fn)
      `LAR_FN_RD_DEMAND: decode_rd = lar_pkg::LAR_SEL_DEMAND;
      `LAR_FN_RD_FRAME:  decode_rd = lar_pkg::LAR_SEL_FRAME;
      `LAR_FN_RD_PARAMS: decode_rd = lar_pkg::LAR_SEL_PARAMS;
      `LAR_FN_RD_ORIGIN: decode_rd = lar_pkg::LAR_SEL_ORIGIN;
      `LAR_FN_RD_LENGTH: decode_rd = lar_pkg::LAR_SEL_LENGTH;
      `LAR_FN_RD_STATUS: decode_rd = lar_pkg::LAR_SEL_STATUS;
      default:           decode_rd = lar_pkg::LAR_SEL_NONE;
    endcase
  endfunction

  // step a buffer displacement, wrapping where it meets the length
  function automatic lar_pkg::lar_ptr_t ptr_step(input lar_pkg::lar_ptr_t p,
                                                 input lar_pkg::lar_ptr_t len);
    lar_pkg::lar_ptr_t n;
    n = 12'(p + 1'b1);
    ptr_step = (n == len) ? `LAR_PTR_RESET : n;
  endfunction

  assign rd_sel    = pio_rd_stb ? decode_rd(pio_func) : lar_pkg::LAR_SEL_NONE;
  assign rd_status = (rd_sel == lar_pkg::LAR_SEL_STATUS);
  assign rd_frame  = (rd_sel == lar_pkg::LAR_SEL_FRAME);
  assign rd_demand = (rd_sel == lar_pkg::LAR_SEL_DEMAND);

  // length field counts 16-cell units so it spans the 12-bit displacement
  assign len_cells = {len_fld_ff, 4'h0};

  // ---------------- write functions ----------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      params_ff <= `LAR_WORD_RESET;
    end else if (pio_wr_stb && pio_func == `LAR_FN_WR_PARAMS) begin
      params_ff <= pio_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      origin_ff <= `LAR_WORD_RESET;
    end else if (pio_wr_stb && pio_func == `LAR_FN_WR_ORIGIN) begin
      origin_ff <= pio_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      thr_ff     <= 4'h0;
      len_fld_ff <= 8'h00;
    end else if (pio_wr_stb && pio_func == `LAR_FN_WR_LENGTH) begin
      thr_ff     <= pio_wdata[`LAR_LEN_THR_HI:`LAR_LEN_THR_LO];
      len_fld_ff <= pio_wdata[`LAR_LEN_FLD_HI:`LAR_LEN_FLD_LO];
    end
  end

  // ---------------- buffer pointers ----------------
  // a zero length matches only when the step wraps to zero, so the pointer then runs the
  // full 4096-cell range; software must program the length before use
  assign nxt_wptr = ptr_step(wptr_ff, len_cells);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wptr_ff <= `LAR_PTR_RESET;
    end else if (cell_wr) begin
      wptr_ff <= nxt_wptr;
    end
  end

  // the frame pointer moves only on a frame's closing cell, so cells of a
  // frame still in progress never show up to the reader
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      frame_ptr_ff <= `LAR_PTR_RESET;
    end else if (cell_wr && frame_end) begin
      frame_ptr_ff <= nxt_wptr;
    end
  end

  // data available: a new frame in the same cycle as the read is kept
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      data_avail_ff <= 1'b0;
    end else if (cell_wr && frame_end) begin
      data_avail_ff <= 1'b1;
    end else if (rd_frame) begin
      data_avail_ff <= 1'b0;
    end
  end

  // ---------------- stored status conditions ----------------
  // an event coinciding with a status read stays set for the next read
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ibuf_full_ff <= 1'b0;
    end else if (ibuf_full_evt) begin
      st_ibuf_full_ff <= 1'b1;
    end else if (rd_status) begin
      st_ibuf_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_out_err_ff <= 1'b0;
    end else if (out_loop_err_evt) begin
      st_out_err_ff <= 1'b1;
    end else if (rd_status) begin
      st_out_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_in_err_ff <= 1'b0;
    end else if (in_loop_err_evt) begin
      st_in_err_ff <= 1'b1;
    end else if (rd_status) begin
      st_in_err_ff <= 1'b0;
    end
  end

  assign any_err = st_ibuf_full_ff | st_out_err_ff | st_in_err_ff;

  always_comb begin
    status_word = `LAR_WORD_RESET;
    if (reset_mode) begin
      status_word = `LAR_STATUS_IN_RESET;
    end else begin
      status_word[`LAR_ST_READY]        = loops_ready;
      status_word[`LAR_ST_ERR_IRQ]      = any_err;
      status_word[`LAR_ST_ONLINE]       = normal_mode && !diag_active;
      status_word[`LAR_ST_IBUF_FULL]    = st_ibuf_full_ff;
      status_word[`LAR_ST_OUT_LOOP_ERR] = st_out_err_ff;
      status_word[`LAR_ST_IN_LOOP_ERR]  = st_in_err_ff;
    end
  end

  // ---------------- demand queue ----------------
  assign dq.push      = demand_push;
  assign dq.push_data = demand_addr;
  assign dq.pop       = rd_demand && !dq.empty;
  assign demand_full  = dq.full;

  // ---------------- read reply ----------------
  always_comb begin
    nxt_rdata = `LAR_WORD_RESET;
    unique case (rd_sel)
      lar_pkg::LAR_SEL_DEMAND: begin
        if (dq.empty) begin
          nxt_rdata = `LAR_DEMAND_EMPTY;
        end else begin
          nxt_rdata = {8'h00, dq.head};
        end
      end
      lar_pkg::LAR_SEL_FRAME: begin
        nxt_rdata = {4'h0, frame_ptr_ff};
      end
      lar_pkg::LAR_SEL_PARAMS: begin
        nxt_rdata = params_ff;
      end
      lar_pkg::LAR_SEL_ORIGIN: begin
        nxt_rdata = origin_ff;
      end
      lar_pkg::LAR_SEL_LENGTH: begin
        nxt_rdata = {thr_ff, len_fld_ff, 4'h0};
      end
      lar_pkg::LAR_SEL_STATUS: begin
        nxt_rdata = status_word;
      end
      lar_pkg::LAR_SEL_NONE: begin
        nxt_rdata = `LAR_WORD_RESET;
      end
    endcase
  end

  // unknown read codes still answer, with zero, since the channel can't reject
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata_ff  <= `LAR_WORD_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= pio_rd_stb;
      if (pio_rd_stb) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign pio_rdata  = rdata_ff;
  assign pio_rvalid = rvalid_ff;

  // ---------------- outputs ----------------
  assign buf_wr_ptr     = wptr_ff;
  assign buf_origin     = origin_ff;
  assign buf_length     = len_cells;
  assign demand_thr     = thr_ff;
  assign secondary_line = params_ff[`LAR_PRM_SECONDARY];
  assign spare_flag     = params_ff[`LAR_PRM_SPARE];
  assign null_count     = params_ff[`LAR_PRM_NULL_HI:`LAR_PRM_NULL_LO];
  assign empty_count    = params_ff[`LAR_PRM_EMPTY_HI:`LAR_PRM_EMPTY_LO];
  assign ext_irq        = any_err;
  assign demand_irq     = !dq.empty;
  assign data_avail_irq = data_avail_ff;
endmodule

// ---- sim/lar_chk_sva.sv ----
`timescale 1ns/100ps
module lar_chk #(
  parameter int DEMAND_DEPTH = 16
) (
  input wire logic        mclk,             // clock
  input wire logic        rst_b,            // reset
  input wire logic [15:0] pio_func,         // code
  input wire logic        pio_rd_stb,       // read
  input wire logic [15:0] pio_rdata,        // reply
  input wire logic        pio_rvalid,       // reply valid
  input wire logic        demand_push,      // push
  input wire logic        demand_full,      // full
  input wire logic        demand_irq,       // demand irq
  input wire logic        cell_wr,          // cell
  input wire logic        frame_end,        // frame end
  input wire logic [11:0] buf_wr_ptr,       // write ptr
  input wire logic [11:0] buf_length,       // length
  input wire logic        reset_mode,       // reset mode
  input wire logic        normal_mode,      // normal
  input wire logic        diag_active,      // diag
  input wire logic        ibuf_full_evt,    // event
  input wire logic        out_loop_err_evt, // event
  input wire logic        in_loop_err_evt,  // event
  input wire logic        ext_irq,          // irq
  input wire logic        data_avail_irq    // irq
);
  logic rd_dem;
  logic rd_frm;
  logic rd_sts;
  logic any_evt;
  assign rd_dem  = pio_rd_stb && pio_func == 16'h0500;
  assign rd_frm  = pio_rd_stb && pio_func == 16'h0560;
  assign rd_sts  = pio_rd_stb && pio_func == 16'h0576;
  assign any_evt = ibuf_full_evt || out_loop_err_evt || in_loop_err_evt;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_DEM_EMPTY: assert property (rd_dem && !demand_irq |=> pio_rdata == 16'h00FF)
    else $error("empty demand read not 00FF");
  AST_DEM_HIGH: assert property (rd_dem |=> pio_rvalid && pio_rdata[15:8] == 8'h00)
    else $error("demand reply high byte set");
  AST_DEM_IRQ: assert property (demand_push && !demand_full |=> demand_irq)
    else $error("demand irq missing after push");
  AST_AVAIL_SET: assert property ($rose(data_avail_irq) |-> $past(cell_wr) && $past(frame_end))
    else $error("data irq rose without frame end");
  AST_FRM_HIGH: assert property (rd_frm |=> pio_rdata[15:12] == 4'h0)
    else $error("frame reply high bits set");
  AST_AVAIL_CLR: assert property (rd_frm && !(cell_wr && frame_end) |=> !data_avail_irq)
    else $error("data irq not cleared");
  AST_PTR_WRAP: assert property (cell_wr && buf_wr_ptr + 12'h001 == buf_length
    |=> buf_wr_ptr == 12'h000) else $error("write pointer did not wrap");
  AST_IRQ_SET: assert property (any_evt |=> ext_irq)
    else $error("ext irq missing after event");
  AST_IRQ_DROP: assert property (rd_sts && !any_evt |=> !ext_irq)
    else $error("ext irq stayed after status read");
  AST_RST_MODE: assert property (rd_sts && reset_mode |=> pio_rdata == 16'h0268)
    else $error("reset mode status wrong");
  AST_ONLINE: assert property (rd_sts && !reset_mode |=>
    pio_rdata[3] == ($past(normal_mode) && !$past(diag_active))) else $error("online bit wrong");
  AST_ERR_OR: assert property (rd_sts && !reset_mode |=>
    pio_rdata[2] == (pio_rdata[9] | pio_rdata[6] | pio_rdata[5])) else $error("bit 2 not OR");
  AST_UNUSED: assert property (rd_sts |=>
    {pio_rdata[15:10], pio_rdata[8:7], pio_rdata[4], pio_rdata[1]} == 10'h000)
    else $error("unused status bit set");
endmodule

// ---- sim/lar_host.sv ----
`timescale 1ns/100ps
module lar_host (
  input  wire logic        mclk,       // clock
  output logic      [15:0] pio_func,   // function code
  output logic             pio_rd_stb, // read strobe
  output logic             pio_wr_stb, // write strobe
  output logic      [15:0] pio_wdata,  // write word
  input  wire logic [15:0] pio_rdata,  // reply word
  input  wire logic        pio_rvalid  // reply valid
);
  initial begin
    pio_func   = 16'h0000;
    pio_rd_stb = 1'b0;
    pio_wr_stb = 1'b0;
    pio_wdata  = 16'h0000;
  end

  task automatic wr(input logic [15:0] f, input logic [15:0] d);
    @(posedge mclk);
    pio_func   <= f;
    pio_wdata  <= d;
    pio_wr_stb <= 1'b1;
    @(posedge mclk);
    pio_wr_stb <= 1'b0;
  endtask

  // reply is a fixed one cycle after the strobe, so no wait loop is needed
  task automatic rd(input logic [15:0] f, output logic [15:0] d, output logic v);
    @(posedge mclk);
    pio_func   <= f;
    pio_rd_stb <= 1'b1;
    @(posedge mclk);
    pio_rd_stb <= 1'b0;
    #1;
    d = pio_rdata;
    v = pio_rvalid;
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
bind lar_top lar_chk #(.DEMAND_DEPTH(DEMAND_DEPTH)) chk_u (.*);
module testbench;
  logic        mclk;
  logic        rst_b, pio_rd_stb, pio_wr_stb, pio_rvalid;
  logic [15:0] pio_func, pio_wdata, pio_rdata, buf_origin;
  logic        demand_push, demand_full, cell_wr, frame_end;
  logic [7:0]  demand_addr, empty_count;
  logic [11:0] buf_wr_ptr, buf_length;
  logic [3:0]  demand_thr;
  logic [4:0]  null_count;
  logic        secondary_line, spare_flag, reset_mode, normal_mode, diag_active;
  logic        loops_ready, ibuf_full_evt, out_loop_err_evt, in_loop_err_evt;
  logic        ext_irq, demand_irq, data_avail_irq;
  int          n_errors = 0;
  int          num_checks = 0;

  lar_top #(.DEMAND_DEPTH(4)) dut_u (.*);
  lar_host host_u (.*);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic rdc(input logic [15:0] f, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host_u.rd(f, d, v);
    chkb(v, 1'b1);
    chk(d, exp);
  endtask

  task automatic cells(input int n, input logic fe);
    for (int i = 1; i <= n; i++) begin
      @(posedge mclk);
      cell_wr   <= 1'b1;
      frame_end <= fe && i == n;
    end
    @(posedge mclk);
    cell_wr   <= 1'b0;
    frame_end <= 1'b0;
    #1;
  endtask

  task automatic t_params();
    logic [15:0] pv [2] = '{16'hA5C3, 16'h5A3C};
    foreach (pv[i]) begin
      host_u.wr(16'h0578, pv[i]);
      rdc(16'h0570, pv[i]);
      rdc(16'h0570, pv[i]);
      chk({1'b0, spare_flag, secondary_line, null_count, empty_count}, pv[i] & 16'h7FFF);
    end
    $display("params test done");
  endtask

  task automatic t_regs();
    host_u.wr(16'h050A, 16'hBEEF);
    host_u.wr(16'h051A, 16'h3025);
    rdc(16'h0502, 16'hBEEF);
    rdc(16'h0512, 16'h3020);
    chk({demand_thr, buf_length}, 16'h3020);
    chk(buf_origin, 16'hBEEF);
    $display("origin and length test done");
  endtask

  // five pushes into a four-deep queue: the last one must be dropped
  task automatic t_demand();
    rdc(16'h0500, 16'h00FF);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      demand_push <= 1'b1;
      demand_addr <= 8'hC3 + 8'(i);
    end
    @(posedge mclk);
    demand_push <= 1'b0;
    #1;
    chkb(demand_irq, 1'b1);
    chkb(demand_full, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rdc(16'h0500, {8'h00, 8'hC3 + 8'(i)});
    end
    chkb(demand_full, 1'b0);
    rdc(16'h0500, 16'h00FF);
    chkb(demand_irq, 1'b0);
    $display("demand test done");
  endtask

  task automatic t_frame();
    host_u.wr(16'h051A, 16'h0010);
    cells(3, 1'b1);
    chkb(data_avail_irq, 1'b1);
    cells(2, 1'b0);
    rdc(16'h0560, 16'h0003);
    chkb(data_avail_irq, 1'b0);
    rdc(16'h0560, 16'h0003);
    // 3 + 2 + 11 cells reach a length of 16, so the last frame ends on the wrap
    cells(11, 1'b1);
    rdc(16'h0560, 16'h0000);
    chk({4'h0, buf_wr_ptr}, 16'h0000);
    $display("frame test done");
  endtask

  task automatic t_status();
    @(posedge mclk);
    reset_mode <= 1'b1;
    rdc(16'h0576, 16'h0268);
    @(posedge mclk);
    reset_mode  <= 1'b0;
    normal_mode <= 1'b1;
    loops_ready <= 1'b1;
    {ibuf_full_evt, out_loop_err_evt, in_loop_err_evt} <= 3'h7;
    @(posedge mclk);
    {ibuf_full_evt, out_loop_err_evt, in_loop_err_evt} <= 3'h0;
    @(posedge mclk);
    #1;
    chkb(ext_irq, 1'b1);
    rdc(16'h0576, 16'h026D);
    chkb(ext_irq, 1'b0);
    rdc(16'h0576, 16'h0009);
    @(posedge mclk);
    diag_active <= 1'b1;
    rdc(16'h0576, 16'h0001);
    // an error landing on the same edge as a status read must survive it
    fork
      begin
        @(posedge mclk);
        in_loop_err_evt <= 1'b1;
        @(posedge mclk);
        in_loop_err_evt <= 1'b0;
      end
    join_none
    rdc(16'h0576, 16'h0001);
    chkb(ext_irq, 1'b1);
    rdc(16'h0576, 16'h0205);
    chkb(ext_irq, 1'b0);
    $display("status test done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    {demand_push, cell_wr, frame_end, reset_mode, normal_mode, diag_active} = 6'h00;
    {loops_ready, ibuf_full_evt, out_loop_err_evt, in_loop_err_evt} = 4'h0;
    demand_addr = 8'h00;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_params();
    t_regs();
    t_demand();
    t_frame();
    t_status();
    close_out();
  end

  // the tests need about 90 cycles; a generous margin avoids false alarms
  initial begin
    #(5000 * 50);
    n_errors++;
    close_out();
  end
endmodule
